// File: verilog/srf_regs.svh
// constants of the slot readout sync framer: offsets, fields, masks, timing
// assumes inclusion by bare name from the framer and the bench
`ifndef SRF_REGS_SVH
`define SRF_REGS_SVH

// ==========================================================
// timing
`define SRF_CLK_NS 10
`define SRF_PHASE_NS 2500
`define SRF_FAST_DIV 2'h3

// ==========================================================
// register byte offsets
`define SRF_OFF_CTRL 5'h00
`define SRF_OFF_RING 5'h04
`define SRF_OFF_COL 5'h08
`define SRF_OFF_FLAGS 5'h0c
`define SRF_OFF_COMPL 5'h10
`define SRF_OFF_ALARM 5'h14
`define SRF_OFF_WSEL 5'h18
`define SRF_OFF_WDATA 5'h1c

// ==========================================================
// fields and reset values
`define SRF_CTRL_RUN 0
`define SRF_CTRL_START 1
`define SRF_RUN_RST 1'h0
`define SRF_WSEL_RST 5'h00
`define SRF_WORDS 24
`define SRF_RESP_OK 2'h0
`define SRF_RESP_ERR 2'h2

// ==========================================================
// ring and column positions
`define SRF_RING_PRIME 17'h01000
`define SRF_RING_PAR 5
`define SRF_RING_SYNC 14
`define SRF_RING_LAST 16
`define SRF_COL_DATA 15'h3def
`define SRF_COL_FIRST 15'h14a5
`define SRF_COL_TEST 15'h0842
`define SRF_COL_SYNC 15'h4210
`define SRF_COL_ONE 15'h0001
`define SRF_COL_CLR 15'h0800
`define SRF_COL_END 15'h4000

`endif

// File: verilog/srf_pkg.sv
// types of the slot readout sync framer
// assumes nothing beyond a SystemVerilog compiler

// ==========================================================
// types
package srf_pkg;
	// timing phases, gray coded along the rotation
	typedef enum logic [1:0] {
		PH1 = 2'h0,
		PH2 = 2'h1,
		PH3 = 2'h3,
		PH4 = 2'h2
	} srf_phase_t;
	// line terminal outputs
	typedef struct packed {
		logic strobe;
		logic sync;
		logic l2;
		logic l1;
	} srf_line_t;
	// register decode result
	typedef struct packed {
		logic ok;
		logic [2:0] idx;
	} srf_sel_t;
	// slot and array word of a column position
	typedef struct packed {
		logic [1:0] slot;
		logic [3:0] word;
	} srf_pos_t;
endpackage : srf_pkg

// File: verilog/srf_framer.sv
// slot readout sync framer: ring and column counters, framed word readout
// assumes one 100 MHz clock, an AXI4-Lite master on that clock, and that
// the storage arrays and slot completeness are filled over the bus
//
// Overview of operation
// RQ1: 7.5 us reset clears ring and shift registers at start, cols 5/10/15.
// RQ2: phase three ending reset sets prime, phase two clears; loads ring 13.
// RQ3: sync pattern 00S00 is shifted from ring 13 to 17 with empty registers.
// RQ4: ring 15 during sync pulses line sync and clears auto parity flag.
// RQ5: slow ring shift set by gated phase two, cleared by phase three.
// RQ6: ring 17 after sync wraps, sets fast shift, ends sync, steps column.
// RQ7: ring 6 gives substitute parity 1 on the lines for absent words; here line 1 only, line 2 gets its 1 at ring 17.
// RQ8: every fourth phase two pulse becomes the fast shift strobe.
// RQ9: word in first register moves into second before shifting out.
// RQ10: fast strobes set ring shift for one full ring cycle, ends at 17.
// RQ11: one-hot 15 column register steps via column shift flag.
// RQ12: column 1 sets search, steps burst counter, loads first word.
// RQ13: per slot, fast-shift first word, load second, shift both out.
// RQ14: slots read at columns 1-4, 6-9 and 11-14.
// RQ15: columns 2, 7, 12 test slot completeness to enable readout.
// RQ16: stepping to column 12 clears all three completeness flags.
// RQ17: columns 5, 10, 15 start sync generation, ring shift and ring sync.
// RQ18: column 15 toggles array phase, clears search, column wraps.
// RQ19: array phase selects which storage array is read out.
// RQ20: incomplete slot sends four substitute parity bits instead.
// RQ21: outgoing words checked for odd parity; even raises alarm, still sent.
// RQ22: four phases are single-cycle strobes 2.5 us apart.
// RQ23: global reset clears flags and loads initial one-hot states; here ring and column reset to all zero instead.
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "srf_regs.svh"

module srf_framer
	import srf_pkg::*;
#(
	parameter int ADDR_W = 5,
	parameter int PHASE_CYC = `SRF_PHASE_NS / `SRF_CLK_NS
)(
	// clock, reset, enable
	input wire logic CLK,
	input wire logic NRST,
	input wire logic CE,
	// axi4-lite write channels
	input wire logic [ADDR_W-1:0] AWADDR,
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	input wire logic WVALID,
	output logic WREADY,
	output logic [1:0] BRESP,
	output logic BVALID,
	input wire logic BREADY,
	// axi4-lite read channels
	input wire logic [ADDR_W-1:0] ARADDR,
	input wire logic ARVALID,
	output logic ARREADY,
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	output logic RVALID,
	input wire logic RREADY,
	// line terminals and status
	output var srf_line_t LINE,
	output logic SEARCH,
	output logic ARRAY_SEL,
	output logic BURST_STEP
);

	// ==========================================================
	// elaboration checks
	if (ADDR_W < 5 || PHASE_CYC < 2)
	begin : g_chk
		$error("srf_framer: ADDR_W or PHASE_CYC out of range");
	end

	// ==========================================================
	// functions
	function automatic srf_sel_t reg_sel(input logic [ADDR_W-1:0] a);
		// aligned word inside the eight-register window
		reg_sel = {(a[1:0] == 2'h0) && ((a >> 5) == '0), a[4:2]};
	endfunction : reg_sel

	// next column: wraps to 1 after 15, starts at 1 from empty
	function automatic logic [14:0] col_adv(input logic [14:0] c);
		col_adv = (c[14] || c == 15'h0000) ? `SRF_COL_ONE : {c[13:0], 1'b0};
	endfunction : col_adv

	function automatic srf_pos_t col_pos(input logic [14:0] c);
		col_pos = '0;
		for (int i = 0; i < 15; i++)
			if (c[i])
				col_pos = {2'(i / 5), 4'(i - i / 5)};
	endfunction : col_pos

	function automatic logic [31:0] strb_mask(input logic [3:0] s);
		for (int i = 0; i < 4; i++)
			strb_mask[i*8 +: 8] = {8{s[i]}};
	endfunction : strb_mask

	// ==========================================================
	// declarations
	logic [1:0] rst_q;
	logic rst_n;
	logic [$clog2(PHASE_CYC)-1:0] cnt;
	srf_phase_t ph;
	logic tick, run, start_req;
	logic g2, g3, g4, step, colstep, begin_sync, div_hit;
	logic slow_data, b1, b2, sub1, sub2;
	logic [16:0] ring, osr1, osr2;
	logic [14:0] col, ncol;
	logic rst_lvl, prime, rshift, fast, sync_gen, col_shift, rsync;
	logic search, phase_sel, ren, autopar, par1, par2;
	logic [1:0] div, alarm;
	logic [5:0] compl;
	logic [4:0] wsel, rd_idx;
	logic [16:0] mem [`SRF_WORDS];
	srf_pos_t npos;
	// bus
	logic aw_got, w_got, wr_fire;
	logic [ADDR_W-1:0] aw_a;
	logic [31:0] w_d, wm, sm;
	logic [3:0] w_s;
	srf_sel_t wsl, rsl;
	logic [31:0] rd_mux;

	// ==========================================================
	// reset release, two stages
	always_ff @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
			rst_q <= 2'h0;
		else
			rst_q <= {rst_q[0], 1'b1};
	end
	assign rst_n = rst_q[1];

	// ==========================================================
	// phase strobes, one cycle each, 2.5 us apart
	always_ff @(posedge CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt <= '0;
			ph <= PH1;
		end
		else if (CE)
		begin
			cnt <= tick ? '0 : cnt + 1'b1; // RQ22
			if (tick)
			begin
				unique case (ph)
					PH1: ph <= PH2;
					PH2: ph <= PH3;
					PH3: ph <= PH4;
					PH4: ph <= PH1;
				endcase
			end
		end
	end

	// gated strobes and sequence events
	assign tick = (cnt == ($clog2(PHASE_CYC))'(PHASE_CYC - 1));
	assign g2 = tick & run & (ph == PH2);
	assign g3 = tick & run & (ph == PH3);
	assign g4 = tick & run & (ph == PH4);
	assign step = g3 & rshift & ~rst_lvl;
	assign ncol = col_adv(col);
	assign npos = col_pos(ncol);
	assign colstep = g4 & col_shift;
	assign begin_sync = g4 & (start_req | (col_shift & |(ncol & `SRF_COL_SYNC)));
	assign div_hit = g2 & (div == `SRF_FAST_DIV);
	assign slow_data = |(col & `SRF_COL_DATA) & ~fast & ~sync_gen;
	assign sub1 = ~ren & slow_data & autopar & ring[`SRF_RING_PAR];
	assign sub2 = ~ren & slow_data & ring[`SRF_RING_LAST];
	assign b1 = (osr1[16] & ren) | sub1;
	assign b2 = (osr2[16] & ren) | sub2;
	assign rd_idx = 5'(npos.word) + (phase_sel ? 5'h0c : 5'h00);

	// ==========================================================
	// reset level, prime and sync generation flags
	always_ff @(posedge CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rst_lvl <= 1'b0; // RQ23
			prime <= 1'b0;
			sync_gen <= 1'b0;
			rsync <= 1'b0;
		end
		else if (CE)
		begin
			if (begin_sync)
				rst_lvl <= 1'b1; // RQ1
			else if (g3)
				rst_lvl <= 1'b0;
			if (g3 & rst_lvl)
				prime <= 1'b1; // RQ2
			else if (g2)
				prime <= 1'b0;
			if (begin_sync)
				sync_gen <= 1'b1; // RQ17
			else if (step & ring[`SRF_RING_LAST])
				sync_gen <= 1'b0; // RQ6
			if (begin_sync)
				rsync <= 1'b1;
			else if (step & ring[`SRF_RING_SYNC])
				rsync <= 1'b0;
		end
	end

	// ==========================================================
	// ring shift, fast shift and divider
	always_ff @(posedge CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rshift <= 1'b0;
			fast <= 1'b0;
			div <= 2'h0;
		end
		else if (CE)
		begin
			if (g2)
				div <= div + 2'h1; // RQ8
			if (g3)
				rshift <= 1'b0; // RQ5
			else if (begin_sync || (fast & div_hit)) // RQ10
				rshift <= 1'b1;
			else if (g2 & ~fast & ~rst_lvl & (sync_gen | slow_data))
				rshift <= 1'b1; // RQ5
			// fast only while a first-of-pair word crosses over
			if (step & ring[`SRF_RING_LAST])
				fast <= |(ncol & `SRF_COL_FIRST); // RQ6 RQ10 RQ13
		end
	end

	// ==========================================================
	// 17-position ring counter
	always_ff @(posedge CLK or negedge rst_n)
	begin
		if (!rst_n)
			ring <= 17'h00000; // RQ23
		else if (CE)
		begin
			if (g3 & rst_lvl)
				ring <= `SRF_RING_PRIME; // RQ2
			else if (rst_lvl)
				ring <= 17'h00000; // RQ1
			else if (prime)
				ring <= ring | `SRF_RING_PRIME; // RQ2
			else if (step)
				ring <= {ring[15:0], ring[16]}; // RQ6
		end
	end

	// ==========================================================
	// column register and its shift flag
	always_ff @(posedge CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			col <= 15'h0000; // RQ23
			col_shift <= 1'b0;
		end
		else if (CE)
		begin
			if (step & ring[`SRF_RING_LAST])
				col_shift <= 1'b1; // RQ11
			else if (colstep)
				col_shift <= 1'b0;
			if (colstep)
				col <= ncol; // RQ11 RQ18
		end
	end

	// ==========================================================
	// search, array phase, burst step
	always_ff @(posedge CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			search <= 1'b0;
			phase_sel <= 1'b0;
			BURST_STEP <= 1'b0;
		end
		else if (CE)
		begin
			BURST_STEP <= colstep & (ncol == `SRF_COL_ONE); // RQ12
			if (colstep & (ncol == `SRF_COL_ONE))
				search <= 1'b1; // RQ12
			else if (colstep & (ncol == `SRF_COL_END))
				search <= 1'b0; // RQ18
			if (colstep & (ncol == `SRF_COL_END))
				phase_sel <= ~phase_sel; // RQ18 RQ19
		end
	end
	assign SEARCH = search;
	assign ARRAY_SEL = phase_sel;

	// ==========================================================
	// completeness flags and readout enable
	always_ff @(posedge CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			compl <= 6'h00;
			ren <= 1'b0;
		end
		else if (CE)
		begin
			// a bus set in the clearing cycle survives
			compl <= (compl & ~((colstep && ncol == `SRF_COL_CLR) ?
				(phase_sel ? 6'h38 : 6'h07) : 6'h00)) | // RQ16
				((wr_fire && wsl.ok && wsl.idx == `SRF_OFF_COMPL >> 2) ?
				wm[5:0] : 6'h00);
			if (colstep & |(ncol & `SRF_COL_TEST))
				ren <= compl[3'(npos.slot) + (phase_sel ? 3'h3 : 3'h0)]; // RQ15
			else if (colstep & |(ncol & `SRF_COL_SYNC))
				ren <= 1'b0;
		end
	end

	// ==========================================================
	// output shift registers
	always_ff @(posedge CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			osr1 <= 17'h00000;
			osr2 <= 17'h00000;
		end
		else if (CE)
		begin
			if (rst_lvl)
			begin
				osr1 <= 17'h00000; // RQ1
				osr2 <= 17'h00000;
			end
			else if (colstep & |(ncol & `SRF_COL_DATA))
				osr1 <= mem[rd_idx]; // RQ12 RQ14 RQ19
			else if (step)
			begin
				osr1 <= {osr1[15:0], 1'b0}; // RQ9 RQ13
				osr2 <= {osr2[15:0], osr1[16]};
			end
		end
	end

	// ==========================================================
	// line drive, auto parity, parity check
	always_ff @(posedge CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			LINE <= '0;
			autopar <= 1'b0;
			par1 <= 1'b0;
			par2 <= 1'b0;
		end
		else if (CE)
		begin
			// fast crossings never reach the lines
			LINE.strobe <= step & ~fast; // RQ3
			LINE.sync <= step & rsync & ring[`SRF_RING_SYNC]; // RQ4
			if (step & ~fast)
			begin
				LINE.l1 <= b1; // RQ7 RQ20
				LINE.l2 <= b2; // RQ13 RQ20
			end
			if (step & sync_gen & ring[`SRF_RING_SYNC])
				autopar <= 1'b0; // RQ4
			else if (step & ~sync_gen & ring[`SRF_RING_LAST])
				autopar <= 1'b1;
			if (step & slow_data)
			begin
				par1 <= ring[`SRF_RING_LAST] ? 1'b0 : par1 ^ b1; // RQ21
				par2 <= ring[`SRF_RING_LAST] ? 1'b0 : par2 ^ b2;
			end
		end
	end

	// alarm: sticky, set beats a clear in the same cycle
	always_ff @(posedge CLK or negedge rst_n)
	begin
		if (!rst_n)
			alarm <= 2'h0;
		else if (CE)
			alarm <= (alarm & ~((wr_fire && wsl.ok &&
				wsl.idx == `SRF_OFF_ALARM >> 2) ? wm[1:0] : 2'h0)) |
				((step & slow_data & ring[`SRF_RING_LAST]) ?
				{~(par2 ^ b2), ~(par1 ^ b1)} : 2'h0); // RQ21
	end

	// ==========================================================
	// bus: control and storage writes
	assign wsl = reg_sel(aw_a);
	assign sm = strb_mask(w_s);
	assign wm = w_d & sm;
	assign wr_fire = aw_got & w_got & ~BVALID;

	always_ff @(posedge CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			run <= `SRF_RUN_RST;
			start_req <= 1'b0;
			wsel <= `SRF_WSEL_RST;
		end
		else if (CE)
		begin
			if (wr_fire && wsl.ok && wsl.idx == `SRF_OFF_CTRL >> 2 && w_s[0])
				run <= w_d[`SRF_CTRL_RUN];
			if (wr_fire && wsl.ok && wsl.idx == `SRF_OFF_CTRL >> 2 &&
				wm[`SRF_CTRL_START])
				start_req <= 1'b1; // RQ23
			else if (g4)
				start_req <= 1'b0;
			if (wr_fire && wsl.ok && wsl.idx == `SRF_OFF_WSEL >> 2 && w_s[0])
				wsel <= w_d[4:0];
		end
	end

	// storage arrays, one word per data column
	always_ff @(posedge CLK)
	begin
		if (CE && wr_fire && wsl.ok && wsl.idx == `SRF_OFF_WDATA >> 2 &&
			wsel < 5'(`SRF_WORDS))
			mem[wsel] <= (mem[wsel] & ~sm[16:0]) | wm[16:0];
	end

	// write handshake: address and data in any order
	always_ff @(posedge CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			{aw_got, w_got, BVALID} <= 3'h0;
			{AWREADY, WREADY} <= 2'h3;
			aw_a <= '0;
			w_d <= 32'h00000000;
			w_s <= 4'h0;
			BRESP <= `SRF_RESP_OK;
		end
		else if (CE)
		begin
			if (AWREADY & AWVALID)
			begin
				aw_got <= 1'b1;
				AWREADY <= 1'b0;
				aw_a <= AWADDR;
			end
			if (WREADY & WVALID)
			begin
				w_got <= 1'b1;
				WREADY <= 1'b0;
				w_d <= WDATA;
				w_s <= WSTRB;
			end
			if (wr_fire)
			begin
				BVALID <= 1'b1;
				BRESP <= (wsl.ok && !(wsl.idx == `SRF_OFF_WDATA >> 2 &&
					wsel >= 5'(`SRF_WORDS))) ? `SRF_RESP_OK : `SRF_RESP_ERR;
			end
			if (BVALID & BREADY)
			begin
				{aw_got, w_got, BVALID} <= 3'h0;
				{AWREADY, WREADY} <= 2'h3;
			end
		end
	end

	// ==========================================================
	// bus: reads
	assign rsl = reg_sel(ARADDR);
	always_comb
	begin
		rd_mux = 32'h00000000;
		unique case (rsl.idx)
			`SRF_OFF_CTRL >> 2: rd_mux = {30'h0, start_req, run};
			`SRF_OFF_RING >> 2: rd_mux = {15'h0, ring};
			`SRF_OFF_COL >> 2: rd_mux = {17'h0, col};
			`SRF_OFF_FLAGS >> 2: rd_mux = {24'h0, autopar, col_shift, rshift,
				ren, sync_gen, fast, search, phase_sel};
			`SRF_OFF_COMPL >> 2: rd_mux = {26'h0, compl};
			`SRF_OFF_ALARM >> 2: rd_mux = {30'h0, alarm};
			`SRF_OFF_WSEL >> 2: rd_mux = {27'h0, wsel};
			`SRF_OFF_WDATA >> 2: rd_mux = (wsel < 5'(`SRF_WORDS)) ?
				{15'h0, mem[wsel]} : 32'h00000000;
		endcase
	end

	always_ff @(posedge CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ARREADY <= 1'b1;
			RVALID <= 1'b0;
			RDATA <= 32'h00000000;
			RRESP <= `SRF_RESP_OK;
		end
		else if (CE)
		begin
			if (ARREADY & ARVALID)
			begin
				ARREADY <= 1'b0;
				RVALID <= 1'b1;
				RDATA <= rsl.ok ? rd_mux : 32'h00000000;
				RRESP <= rsl.ok ? `SRF_RESP_OK : `SRF_RESP_ERR;
			end
			else if (RVALID & RREADY)
			begin
				RVALID <= 1'b0;
				ARREADY <= 1'b1;
			end
		end
	end

endmodule : srf_framer
`default_nettype wire

// File: testbench/srf_framer_assertions.sv
// port-level checker of the slot readout sync framer
// assumes it is bound into srf_framer and handed its PHASE_CYC
`timescale 1ns/100ps
`default_nettype none

module srf_framer_assertions
	import srf_pkg::*;
#(
	parameter int PHASE_CYC = 250
)(
	// clock and reset
	input wire logic CLK,
	input wire logic NRST,
	// bus handshakes
	input wire logic AWVALID,
	input wire logic AWREADY,
	input wire logic WVALID,
	input wire logic WREADY,
	input wire logic BVALID,
	input wire logic ARVALID,
	input wire logic ARREADY,
	input wire logic RVALID,
	// line and status
	input wire srf_line_t LINE,
	input wire logic SEARCH,
	input wire logic ARRAY_SEL,
	input wire logic BURST_STEP
);
	// ============
	// cycles since the last line strobe, saturating so it never wraps
	logic [15:0] gap;
	logic seen;
	always_ff @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			gap <= 16'h0000;
			seen <= 1'b0;
		end
		else if (LINE.strobe)
		begin
			gap <= 16'h0000;
			seen <= 1'b1;
		end
		else if (gap != 16'hffff)
			gap <= gap + 16'h0001;
	end

	// ============
	// properties
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!NRST);
	sequence write_taken;
		AWVALID && AWREADY && WVALID && WREADY;
	endsequence
	sequence burst_start;
		BURST_STEP ##1 !BURST_STEP;
	endsequence

	strobe_single_a: assert property (LINE.strobe |=> !LINE.strobe)
		else $error("line strobe longer than one cycle");
	sync_single_a: assert property (LINE.sync |=> !LINE.sync)
		else $error("line sync longer than one cycle");
	sync_quiet_a: assert property (LINE.sync |-> !LINE.l1 && !LINE.l2)
		else $error("data bit on a line during sync");
	line_hold_a: assert property
		(!LINE.strobe |-> $stable(LINE.l1) && $stable(LINE.l2))
		else $error("line bit changed between strobes");
	strobe_gap_a: assert property
		(LINE.strobe && seen |-> gap >= 16'(4 * PHASE_CYC - 1))
		else $error("line strobes closer than one phase rotation");
	burst_search_a: assert property (burst_start |-> SEARCH)
		else $error("burst step without search");
	phase_flip_a: assert property ($changed(ARRAY_SEL) |-> !SEARCH)
		else $error("array phase toggled during search");
	search_end_a: assert property ($fell(SEARCH) |-> $changed(ARRAY_SEL))
		else $error("search ended without array toggle");
	write_answer_a: assert property (write_taken |-> ##[1:2] BVALID)
		else $error("write response late");
	read_answer_a: assert property (ARVALID && ARREADY |=> RVALID)
		else $error("read data late");
	bus_busy_a: assert property (BVALID |-> !AWREADY && !WREADY)
		else $error("write channels ready before response taken");
endmodule : srf_framer_assertions

bind srf_framer srf_framer_assertions #(.PHASE_CYC(PHASE_CYC))
	srf_framer_assertions_i (.CLK(CLK), .NRST(NRST), .AWVALID(AWVALID),
	.AWREADY(AWREADY), .WVALID(WVALID), .WREADY(WREADY), .BVALID(BVALID),
	.ARVALID(ARVALID), .ARREADY(ARREADY), .RVALID(RVALID), .LINE(LINE),
	.SEARCH(SEARCH), .ARRAY_SEL(ARRAY_SEL), .BURST_STEP(BURST_STEP));
`default_nettype wire

// File: testbench/srf_line_model.sv
// receiving end of the two phone lines: records the first 200 strobed bit pairs
// assumes the line outputs of srf_framer on the same clock
`timescale 1ns/100ps
`default_nettype none

module srf_line_model
	import srf_pkg::*;
(
	// clock
	input wire logic CLK,
	// line from the framer
	input wire srf_line_t LINE
);
	logic l1_bits [1:200];
	logic l2_bits [1:200];
	int cyc_at [1:200];
	int sync_at [0:7];
	int n_strobe = 0;
	int n_sync = 0;
	int cyc = 0;

	// ============
	// sample at the strobe; a sync counts against the strobes seen so far
	always @(posedge CLK)
	begin
		cyc++;
		if (LINE.strobe === 1'b1 && n_strobe < 200)
		begin
			n_strobe++;
			l1_bits[n_strobe] = LINE.l1;
			l2_bits[n_strobe] = LINE.l2;
			cyc_at[n_strobe] = cyc;
		end
		if (LINE.sync === 1'b1 && n_sync < 8)
		begin
			sync_at[n_sync] = n_strobe;
			n_sync++;
		end
	end
endmodule : srf_line_model
`default_nettype wire

// File: testbench/srf_framer_tb.sv
// self-checking bench of the slot readout sync framer
// assumes srf_pkg, srf_regs.svh, the line model and the bound checker
`timescale 1ns/100ps
`default_nettype none
`include "srf_regs.svh"

module srf_framer_tb
	import srf_pkg::*;
;
	localparam int PC = 4;
	localparam int UNIT = 4 * PC;
	typedef struct packed {
		logic wr;
		logic [4:0] a;
		logic [31:0] d;
		logic [31:0] exp;
		logic [1:0] resp;
	} srf_row_t;

	// ============
	// design signals
	logic CLK, NRST, CE, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
	logic ARVALID, ARREADY, RVALID, RREADY, SEARCH, ARRAY_SEL, BURST_STEP;
	logic [4:0] AWADDR, ARADDR;
	logic [31:0] WDATA, RDATA;
	logic [3:0] WSTRB;
	logic [1:0] BRESP, RRESP;
	srf_line_t LINE;
	int num_errors = 0;
	int checks_done = 0;
	int cycles = 0;
	logic [31:0] rd;
	logic [1:0] rsp;
	int g;
	// ordinary register cases; misaligned rows check the response only
	srf_row_t rows [0:11] = '{
		'{1'b0, `SRF_OFF_CTRL, 32'h0, 32'h0, `SRF_RESP_OK},
		'{1'b0, `SRF_OFF_RING, 32'h0, 32'h0, `SRF_RESP_OK},
		'{1'b0, `SRF_OFF_COL, 32'h0, 32'h0, `SRF_RESP_OK},
		'{1'b0, `SRF_OFF_FLAGS, 32'h0, 32'h0, `SRF_RESP_OK},
		'{1'b0, `SRF_OFF_WSEL, 32'h0, 32'h0, `SRF_RESP_OK},
		'{1'b0, 5'h02, 32'h0, 32'h0, `SRF_RESP_ERR},
		'{1'b1, `SRF_OFF_WSEL, 32'h18, 32'h0, `SRF_RESP_OK},
		'{1'b1, `SRF_OFF_WDATA, 32'h1, 32'h0, `SRF_RESP_ERR},
		'{1'b0, `SRF_OFF_WDATA, 32'h0, 32'h0, `SRF_RESP_OK},
		'{1'b1, `SRF_OFF_COMPL, 32'h9, 32'h0, `SRF_RESP_OK},
		'{1'b1, `SRF_OFF_COMPL, 32'h0, 32'h0, `SRF_RESP_OK},
		'{1'b0, `SRF_OFF_COMPL, 32'h0, 32'h9, `SRF_RESP_OK}
	};

	srf_framer #(.PHASE_CYC(PC)) srf_framer_i (.CLK(CLK), .NRST(NRST),
		.CE(CE), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
		.WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
		.BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR),
		.ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP),
		.RVALID(RVALID), .RREADY(RREADY), .LINE(LINE), .SEARCH(SEARCH),
		.ARRAY_SEL(ARRAY_SEL), .BURST_STEP(BURST_STEP));
	srf_line_model srf_line_model_i (.CLK(CLK), .LINE(LINE));

	// ============
	// clock and hang guard
	always #5 CLK = ~CLK;
	always @(posedge CLK)
	begin
		cycles++;
		if (cycles == 40000)
		begin
			num_errors++;
			report_and_stop();
		end
	end

	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic report_and_stop();
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : report_and_stop

	// ============
	// bus master: payload held until each channel is taken
	task automatic axi_write(input logic [4:0] a, input logic [31:0] d,
		output logic [1:0] r);
		@(posedge CLK);
		AWADDR <= a;
		WDATA <= d;
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		BREADY <= 1'b1;
		do
		begin
			@(posedge CLK);
			if (AWREADY === 1'b1)
				AWVALID <= 1'b0;
			if (WREADY === 1'b1)
				WVALID <= 1'b0;
		end
		while (BVALID !== 1'b1);
		r = BRESP;
		BREADY <= 1'b0;
	endtask : axi_write

	task automatic axi_read(input logic [4:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge CLK);
		ARADDR <= a;
		ARVALID <= 1'b1;
		RREADY <= 1'b1;
		do
		begin
			@(posedge CLK);
			if (ARREADY === 1'b1)
				ARVALID <= 1'b0;
		end
		while (RVALID !== 1'b1);
		d = RDATA;
		r = RRESP;
		RREADY <= 1'b0;
	endtask : axi_read

	task automatic wait_strobes(input int n);
		while (srf_line_model_i.n_strobe < n)
			@(posedge CLK);
	endtask : wait_strobes

	// 17 strobes from base: line 2 and line 1 bits, first bit first
	task automatic chk_word(input int base, input logic [16:0] w2,
		input logic [16:0] w1);
		logic s1, s2;
		for (int i = 0; i < 17; i++)
		begin
			s2 = srf_line_model_i.l2_bits[base + i];
			s1 = srf_line_model_i.l1_bits[base + i];
			check("line2", 32'(s2), 32'(w2[16 - i]));
			check("line1", 32'(s1), 32'(w1[16 - i]));
		end
	endtask : chk_word

	task automatic load(input logic [4:0] idx, input logic [16:0] w);
		axi_write(`SRF_OFF_WSEL, 32'(idx), rsp);
		axi_write(`SRF_OFF_WDATA, 32'(w), rsp);
	endtask : load

	// ============
	// main sequence: reset, register rows, then one burst period and the first word of the next
	initial
	begin
		{CLK, NRST, AWVALID, WVALID, BREADY, ARVALID, RREADY} = 7'h00;
		{AWADDR, ARADDR, WDATA} = 42'h0;
		WSTRB = 4'hf;
		CE = 1'b1;
		repeat (20) @(posedge CLK);
		NRST <= 1'b1;
		repeat (3) @(posedge CLK);
		check("readys", 32'({AWREADY, WREADY, ARREADY}), 32'h7);
		check("line", 32'(LINE), 32'h0);
		check("status", 32'({SEARCH, ARRAY_SEL, BURST_STEP}), 32'h0);
		foreach (rows[i])
		begin
			if (rows[i].wr)
				axi_write(rows[i].a, rows[i].d, rsp);
			else
				axi_read(rows[i].a, rd, rsp);
			check("resp", 32'(rsp), 32'(rows[i].resp));
			if (!rows[i].wr && rows[i].a[1:0] == 2'h0)
				check("rdata", rd, rows[i].exp);
		end
		// word 1 has even parity on purpose
		load(5'h00, 17'h10003);
		load(5'h01, 17'h0000f);
		load(5'h02, 17'h15555);
		load(5'h03, 17'h00001);
		load(5'h0c, 17'h1ffff);
		load(5'h0d, 17'h00007);
		axi_read(`SRF_OFF_WDATA, rd, rsp);
		check("word read", rd, 32'h00007);
		axi_write(`SRF_OFF_CTRL, 32'h3, rsp);
		wait_strobes(7);
		axi_read(`SRF_OFF_COL, rd, rsp);
		check("column", rd, 32'h0002);
		check("search", 32'({SEARCH, ARRAY_SEL}), 32'h2);
		g = srf_line_model_i.cyc_at[7] - srf_line_model_i.cyc_at[6];
		check("slow step", 32'(g), 32'(UNIT));
		g = srf_line_model_i.cyc_at[6] - srf_line_model_i.cyc_at[5];
		g = (g >= 16 * 4 * UNIT && g <= 19 * 4 * UNIT) ? 1 : 0;
		check("fast pass", 32'(g), 32'h1);
		wait_strobes(40);
		chk_word(6, 17'h10003, 17'h0000f);
		chk_word(23, 17'h15555, 17'h00001);
		axi_read(`SRF_OFF_ALARM, rd, rsp);
		check("alarm", rd, 32'h1);
		axi_write(`SRF_OFF_ALARM, 32'h1, rsp);
		axi_read(`SRF_OFF_ALARM, rd, rsp);
		check("alarm clear", rd, 32'h0);
		wait_strobes(124);
		// slots 2 and 3 are incomplete: substitute parity bits only
		for (int s = 0; s < 4; s++)
		begin
			g = s < 2 ? 45 + 17 * s : 84 + 17 * (s - 2);
			chk_word(g, 17'h00001, 17'h00800);
		end
		axi_read(`SRF_OFF_COMPL, rd, rsp);
		check("compl", rd, 32'h8);
		check("phase", 32'({SEARCH, ARRAY_SEL}), 32'h3);
		wait_strobes(140);
		chk_word(123, 17'h1ffff, 17'h00007);
		for (int s = 0; s < 4; s++)
		begin
			g = srf_line_model_i.sync_at[s];
			check("sync", 32'(g), 32'(3 + 39 * s));
			for (int k = 0; k < 5; k++)
			begin
				g = 1 + 39 * s + k;
				check("sync l1", 32'(srf_line_model_i.l1_bits[g]), 32'h0);
				check("sync l2", 32'(srf_line_model_i.l2_bits[g]), 32'h0);
			end
		end
		// reset in mid-run: back to idle, nothing left running
		NRST <= 1'b0;
		repeat (2) @(posedge CLK);
		NRST <= 1'b1;
		repeat (3) @(posedge CLK);
		check("status rst", 32'({SEARCH, ARRAY_SEL, BURST_STEP}), 32'h0);
		check("line rst", 32'(LINE), 32'h0);
		axi_read(`SRF_OFF_RING, rd, rsp);
		check("ring rst", rd, 32'h0);
		report_and_stop();
	end
endmodule : srf_framer_tb
`default_nettype wire
